// File: rtl/afr_pkg.sv
/*
  Shared constants, field layouts and types of the audio format and
  headset input gain register block.
  Assumes a single 40 MHz clock and a register port of 4 address bits
  and 16 data bits.
*/
package afr_pkg;

  // ----------------------------------------------------------------
  // Register port and map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFS_AUDIO_FMT = 4'h0;
  localparam logic [3:0] OFS_INPUT_GAIN = 4'h1;
  localparam logic [3:0] OFS_RSVD_FILL = 4'hE;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HPF_LSB = 14;
  localparam int SAMPLE_WORD_WIDTH_LSB = 10;
  localparam int FMT_LSB = 8;
  localparam int PLAYBACK_RATE_DIVIDER_LSB = 3;
  localparam int RECORD_RATE_DIVIDER_LSB = 0;
  localparam int MUTE_BIT = 15;
  localparam int GAIN_LSB = 8;
  localparam int TGT_LSB = 5;
  localparam int TC_LSB = 1;
  localparam int AGC_EN_BIT = 0;
  localparam int FILL_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [15:0] AUDIO_FMT_RST = 16'h0000;
  localparam logic [15:0] AUDIO_FMT_WMASK = 16'hCF3F;
  localparam logic [15:0] INPUT_GAIN_RST = 16'hFF00;
  localparam logic [7:0] FILL_RST = 8'hFF;
  localparam logic [6:0] GAIN_MAX = 7'h7F;

  // ----------------------------------------------------------------
  // Lookup tables, index is the field code
  // ----------------------------------------------------------------
  localparam logic [3:0][5:0] WORD_BITS = {6'h20, 6'h18, 6'h14, 6'h10};
  localparam logic [7:0][3:0] DAC_DIV2 =
    {4'hC, 4'hA, 4'hA, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2};
  localparam logic [7:0][3:0] ADC_DIV2 =
    {4'hC, 4'hB, 4'hA, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2};
  localparam logic [7:0][7:0] TGT_HALF_DB =
    {8'h30, 8'h28, 8'h22, 8'h1C, 8'h18, 8'h14, 8'h10, 8'h0B};
  localparam logic [3:0][8:0] ATTACK_MS = {9'h014, 9'h010, 9'h00B, 9'h008};
  localparam logic [3:0][8:0] DECAY_MS = {9'h1F4, 9'h190, 9'h0C8, 9'h064};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HPF_OFF = 2'h0,
    HPF_0045 = 2'h1,
    HPF_0125 = 2'h2,
    HPF_0250 = 2'h3
  } afr_hpf_t;

  typedef enum logic [1:0] {
    FMT_I2S = 2'h0,
    FMT_DSP = 2'h1,
    FMT_RIGHT = 2'h2,
    FMT_LEFT = 2'h3
  } afr_framing_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } afr_bus_req_t;

  typedef struct packed {
    afr_hpf_t adc_highpass_select;
    logic [5:0] sample_word_width;
    afr_framing_t serial_framing_format;
    logic [3:0] playback_rate_divider;
    logic [3:0] record_rate_divider;
  } afr_fmt_cfg_t;

  typedef struct packed {
    logic headset_input_mute;
    logic [6:0] headset_input_gain;
    logic auto_gain_active;
  } afr_gain_t;

endpackage

// File: rtl/afr_rate_div.sv
/*
  Fractional sample-rate strobe divider, steps of one half.
  Assumes the reference rate arrives as a one-cycle enable pulse on
  the same clock and the ratio is given in half steps, at least two.
*/
`timescale 1ns/1ps
module afr_rate_div (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic fsref_tick,
  input wire logic [3:0] div2,
  output logic fs_tick
);
  import afr_pkg::*;

  typedef struct packed {
    logic [4:0] acc;
    logic tick;
  } afr_div_st_t;

  afr_div_st_t st_r;
  afr_div_st_t st_nxt;
  logic [4:0] sum;

  always_comb
  begin
    st_nxt = st_r;
    sum = st_r.acc + 5'h02;
    st_nxt.tick = 1'b0;
    if (fsref_tick)
    begin
      if (sum >= {1'b0, div2})
      begin
        st_nxt.tick = 1'b1;
        st_nxt.acc = sum - {1'b0, div2};
      end
      else
      begin
        st_nxt.acc = sum;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign fs_tick = st_r.tick;
endmodule

// File: rtl/afr_agc.sv
/*
  Automatic gain loop for the headset input amplifier.
  Assumes a one-cycle millisecond tick and a level input on the same
  clock, given as attenuation below full scale in half decibels.
*/
`timescale 1ns/1ps
module afr_agc (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic ms_tick,
  input wire logic [6:0] load_gain,
  input wire logic [2:0] target_sel,
  input wire logic [3:0] time_sel,
  input wire logic [7:0] level_half_db,
  output logic [6:0] gain
);
  import afr_pkg::*;

  typedef struct packed {
    logic en_d;
    logic [6:0] gain;
    logic [8:0] ms_cnt;
  } afr_agc_st_t;

  afr_agc_st_t st_r;
  afr_agc_st_t st_nxt;
  logic [8:0] cnt_inc;
  logic louder;
  logic quieter;

  always_comb
  begin
    st_nxt = st_r;
    cnt_inc = st_r.ms_cnt + 9'h001;
    louder = level_half_db < TGT_HALF_DB[target_sel];
    quieter = level_half_db > TGT_HALF_DB[target_sel];
    st_nxt.en_d = enable;
    if (enable && !st_r.en_d)
    begin
      st_nxt.gain = load_gain;
      st_nxt.ms_cnt = '0;
    end
    else if (enable && ms_tick)
    begin
      st_nxt.ms_cnt = cnt_inc;
      if (louder)
      begin
        if (cnt_inc >= ATTACK_MS[time_sel[1:0]])
        begin
          st_nxt.ms_cnt = '0;
          if (st_r.gain != 7'h00)
          begin
            st_nxt.gain = st_r.gain - 7'h01;
          end
        end
      end
      else if (quieter)
      begin
        if (cnt_inc >= DECAY_MS[time_sel[3:2]])
        begin
          st_nxt.ms_cnt = '0;
          if (st_r.gain != GAIN_MAX)
          begin
            st_nxt.gain = st_r.gain + 7'h01;
          end
        end
      end
      else
      begin
        st_nxt.ms_cnt = '0;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign gain = st_r.gain;
endmodule

// File: rtl/afr_regs.sv
/*
  Audio format, sample-rate and headset input gain register block,
  with the rate strobes and the automatic gain loop it steers.
  Assumes software on the same clock drives the register port, the
  page selection is decoded outside, and fsref_tick, level_half_db and
  headset_selected come from logic on ref_clk.
*/
// Design decision made here: strobed register access.
`timescale 1ns/1ps

module afr_regs #(
  parameter int CYC_PER_MS_P = afr_pkg::CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire afr_pkg::afr_bus_req_t bus_req,
  output logic [afr_pkg::DATA_W-1:0] rdata,
  input wire logic fsref_tick,
  input wire logic headset_selected,
  input wire logic [7:0] level_half_db,
  output afr_pkg::afr_fmt_cfg_t fmt_cfg,
  output afr_pkg::afr_gain_t applied_gain,
  output logic [2:0] auto_gain_target_level,
  output logic [3:0] auto_gain_time_constants,
  output logic playback_fs_tick,
  output logic record_fs_tick
);
  import afr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] audio_format_rate_control;
    logic [15:0] input_gain_agc_control;
    logic [7:0] reserved_fill_bits;
    logic [15:0] rdata;
    logic [15:0] ms_cnt;
    logic ms_tick;
    afr_fmt_cfg_t cfg;
    afr_gain_t gain;
  } afr_regs_st_t;

  afr_regs_st_t st_r;
  afr_regs_st_t st_nxt;
  logic [6:0] agc_gain;
  logic agc_en;
  logic agc_owns;
  logic [15:0] fmt_w;
  logic [15:0] gain_w;
  logic [15:0] gain_rd;

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  assign fmt_w = st_r.audio_format_rate_control;
  assign gain_w = st_r.input_gain_agc_control;
  assign agc_en = gain_w[AGC_EN_BIT];
  assign agc_owns = agc_en && headset_selected;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    gain_rd = gain_w;
    if (agc_owns)
    begin
      gain_rd[MUTE_BIT] = 1'b0;
      gain_rd[GAIN_LSB +: 7] = agc_gain;
    end

    // Millisecond enable for the gain loop timing.
    st_nxt.ms_tick = 1'b0;
    if (st_r.ms_cnt == 16'(CYC_PER_MS_P - 1))
    begin
      st_nxt.ms_cnt = '0;
      st_nxt.ms_tick = 1'b1;
    end
    else
    begin
      st_nxt.ms_cnt = st_r.ms_cnt + 16'h0001;
    end

    // Register writes.
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        OFS_AUDIO_FMT:
        begin
          st_nxt.audio_format_rate_control = bus_req.wdata & AUDIO_FMT_WMASK;
        end
        OFS_INPUT_GAIN:
        begin
          st_nxt.input_gain_agc_control = bus_req.wdata;
        end
        OFS_RSVD_FILL:
        begin
          st_nxt.reserved_fill_bits = bus_req.wdata[FILL_LSB +: 8];
        end
        default:
        begin
          st_nxt.rdata = st_nxt.rdata;
        end
      endcase
    end

    // Read data stands one cycle after the read strobe only.
    st_nxt.rdata = '0;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        OFS_AUDIO_FMT:
        begin
          st_nxt.rdata = fmt_w & AUDIO_FMT_WMASK;
        end
        OFS_INPUT_GAIN:
        begin
          st_nxt.rdata = gain_rd;
        end
        OFS_RSVD_FILL:
        begin
          st_nxt.rdata = {st_r.reserved_fill_bits, 8'h00};
        end
        default:
        begin
          st_nxt.rdata = '0;
        end
      endcase
    end

    // Decoded converter configuration.
    st_nxt.cfg.adc_highpass_select = afr_hpf_t'(fmt_w[HPF_LSB +: 2]);
    st_nxt.cfg.sample_word_width = WORD_BITS[fmt_w[SAMPLE_WORD_WIDTH_LSB +: 2]];
    st_nxt.cfg.serial_framing_format = afr_framing_t'(fmt_w[FMT_LSB +: 2]);
    st_nxt.cfg.playback_rate_divider = DAC_DIV2[fmt_w[PLAYBACK_RATE_DIVIDER_LSB +: 3]];
    st_nxt.cfg.record_rate_divider = ADC_DIV2[fmt_w[RECORD_RATE_DIVIDER_LSB +: 3]];

    // Gain actually applied to the headset input amplifier.
    if (agc_en)
    begin
      st_nxt.gain.headset_input_mute = 1'b0;
      st_nxt.gain.headset_input_gain = agc_gain;
      st_nxt.gain.auto_gain_active = 1'b1;
    end
    else
    begin
      st_nxt.gain.headset_input_mute = gain_w[MUTE_BIT];
      st_nxt.gain.headset_input_gain = gain_w[GAIN_LSB +: 7];
      st_nxt.gain.auto_gain_active = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r.audio_format_rate_control <= AUDIO_FMT_RST;
      st_r.input_gain_agc_control <= INPUT_GAIN_RST;
      st_r.reserved_fill_bits <= FILL_RST;
      st_r.rdata <= '0;
      st_r.ms_cnt <= '0;
      st_r.ms_tick <= 1'b0;
      st_r.cfg.adc_highpass_select <= HPF_OFF;
      st_r.cfg.sample_word_width <= WORD_BITS[0];
      st_r.cfg.serial_framing_format <= FMT_I2S;
      st_r.cfg.playback_rate_divider <= DAC_DIV2[0];
      st_r.cfg.record_rate_divider <= ADC_DIV2[0];
      st_r.gain.headset_input_mute <= INPUT_GAIN_RST[MUTE_BIT];
      st_r.gain.headset_input_gain <= INPUT_GAIN_RST[GAIN_LSB +: 7];
      st_r.gain.auto_gain_active <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Rate strobes
  // ----------------------------------------------------------------
  afr_rate_div u_dac_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .fsref_tick(fsref_tick),
    .div2(st_r.cfg.playback_rate_divider),
    .fs_tick(playback_fs_tick)
  );

  afr_rate_div u_adc_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .fsref_tick(fsref_tick),
    .div2(st_r.cfg.record_rate_divider),
    .fs_tick(record_fs_tick)
  );

  // ----------------------------------------------------------------
  // Automatic gain loop
  // ----------------------------------------------------------------
  afr_agc u_agc (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(agc_en),
    .ms_tick(st_r.ms_tick),
    .load_gain(gain_w[GAIN_LSB +: 7]),
    .target_sel(gain_w[TGT_LSB +: 3]),
    .time_sel(gain_w[TC_LSB +: 4]),
    .level_half_db(level_half_db),
    .gain(agc_gain)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata = st_r.rdata;
  assign fmt_cfg = st_r.cfg;
  assign applied_gain = st_r.gain;
  assign auto_gain_target_level = gain_w[TGT_LSB +: 3];
  assign auto_gain_time_constants = gain_w[TC_LSB +: 4];
endmodule

// File: verif/afr_regs_properties.sv
/*
  Concurrent checks on the ports of the audio format and input gain block.
  Assumes a bind to afr_regs on one clock with synchronous reset.
*/
`timescale 1ns/1ps
module afr_regs_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire afr_pkg::afr_bus_req_t bus_req,
  input wire logic [afr_pkg::DATA_W-1:0] rdata,
  input wire logic fsref_tick,
  input wire afr_pkg::afr_fmt_cfg_t fmt_cfg,
  input wire afr_pkg::afr_gain_t applied_gain,
  input wire logic [2:0] auto_gain_target_level,
  input wire logic [3:0] auto_gain_time_constants,
  input wire logic playback_fs_tick,
  input wire logic record_fs_tick
);
  import afr_pkg::*;
  // ----------------------------------------------------------------
  // Decode tables and helpers
  // ----------------------------------------------------------------
  localparam logic [5:0] WB [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
  localparam logic [3:0] DH [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hA, 4'hC};
  localparam logic [3:0] AH [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hB, 4'hC};
  wire fmt_wr = bus_req.wr && bus_req.addr == OFS_AUDIO_FMT;
  wire gain_wr = bus_req.wr && bus_req.addr == OFS_INPUT_GAIN;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  fmt_fields_a: assert property (fmt_wr |-> ##2
    fmt_cfg.adc_highpass_select == $past(bus_req.wdata[15:14], 2) &&
    fmt_cfg.serial_framing_format == $past(bus_req.wdata[9:8], 2))
    else $error("format fields wrong");
  word_width_a: assert property (fmt_wr |-> ##2
    fmt_cfg.sample_word_width == WB[$past(bus_req.wdata[11:10], 2)])
    else $error("word width wrong");
  dac_divider_a: assert property (fmt_wr |-> ##2
    fmt_cfg.playback_rate_divider == DH[$past(bus_req.wdata[5:3], 2)])
    else $error("playback divider wrong");
  adc_divider_a: assert property (fmt_wr |-> ##2
    fmt_cfg.record_rate_divider == AH[$past(bus_req.wdata[2:0], 2)])
    else $error("record divider wrong");
  manual_gain_a: assert property (gain_wr && !bus_req.wdata[0] |-> ##2
    !applied_gain.auto_gain_active &&
    applied_gain.headset_input_mute == $past(bus_req.wdata[15], 2) &&
    applied_gain.headset_input_gain == $past(bus_req.wdata[14:8], 2))
    else $error("manual gain wrong");
  agc_owns_a: assert property (gain_wr && bus_req.wdata[0] |-> ##2
    applied_gain.auto_gain_active && !applied_gain.headset_input_mute)
    else $error("gain loop not in control");
  agc_fields_a: assert property (gain_wr ##1 !gain_wr |-> ##1
    auto_gain_target_level == $past(bus_req.wdata[7:5], 2) &&
    auto_gain_time_constants == $past(bus_req.wdata[4:1], 2))
    else $error("gain loop fields wrong");
  fmt_reserved_a: assert property (bus_req.rd && bus_req.addr == OFS_AUDIO_FMT |=>
    rdata[13:12] == 2'h0 && rdata[7:6] == 2'h0)
    else $error("reserved format bits not zero");
  fill_low_a: assert property (bus_req.rd && bus_req.addr == OFS_RSVD_FILL |=>
    rdata[7:0] == 8'h00)
    else $error("fill low byte not zero");
  rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 16'h0000)
    else $error("read data outside read cycle");
  tick_cause_a: assert property (playback_fs_tick || record_fs_tick |-> $past(fsref_tick))
    else $error("rate tick without reference tick");
endmodule

// File: verif/afr_regs_tb_top.sv
/*
  Self-checking bench for the audio format and input gain register block.
  Assumes the checker file is compiled first; shortens the millisecond count.
*/
`timescale 1ns/1ps
module afr_regs_tb_top;
  import afr_pkg::*;
  localparam int MS_P = 10;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  afr_bus_req_t bus_req = '0;
  logic [DATA_W-1:0] rdata;
  logic fsref_tick = 1'b0;
  logic headset_selected = 1'b0;
  logic [7:0] level_half_db = 8'h00;
  afr_fmt_cfg_t fmt_cfg;
  afr_gain_t applied_gain;
  logic [2:0] auto_gain_target_level;
  logic [3:0] auto_gain_time_constants;
  logic playback_fs_tick;
  logic record_fs_tick;
  int n_errors = 0;
  int checks = 0;
  int seed = 32'hF4594E30;
  logic rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  logic [5:0] wbits [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
  logic [3:0] dac_h [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hA, 4'hC};
  logic [3:0] adc_h [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hB, 4'hC};

  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  afr_regs #(.CYC_PER_MS_P(MS_P)) afr_regs_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus_req(bus_req),
    .rdata(rdata),
    .fsref_tick(fsref_tick),
    .headset_selected(headset_selected),
    .level_half_db(level_half_db),
    .fmt_cfg(fmt_cfg),
    .applied_gain(applied_gain),
    .auto_gain_target_level(auto_gain_target_level),
    .auto_gain_time_constants(auto_gain_time_constants),
    .playback_fs_tick(playback_fs_tick),
    .record_fs_tick(record_fs_tick)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
  endtask

  task automatic rd_exp(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask

  task automatic wait_gain(input logic [6:0] g, input int limit);
    int i;
    for (i = 0; i < limit && applied_gain.headset_input_gain !== g; i++)
      @(posedge ref_clk);
    if (i == limit)
    begin
      n_errors++;
      $display("[FAIL] %0t gain wait timed out", $time);
      print_verdict();
    end
  endtask

  // Read results are taken off the queue in the cycle after each read.
  always @(posedge ref_clk)
  begin
    if (rd_seen)
      check(32'(rdata), 32'(exp_q.pop_front()), "read data");
    rd_seen <= bus_req.rd;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] d;
    logic [15:0] r;
    int n;
    int m;
    logic [1:0] f;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd_exp(OFS_AUDIO_FMT, 16'h0000);
    rd_exp(OFS_INPUT_GAIN, 16'hFF00);
    rd_exp(OFS_RSVD_FILL, 16'hFF00);
    check(32'(fmt_cfg), 32'h4022, "reset format");
    check(32'(applied_gain), 32'h1FE, "reset gain");
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      r = 16'($random(seed));
      f = i[1:0] ^ {~i[2], i[2]};
      d = {i[1:0], r[13:12], i[1:0], f, r[7:6], i[2:0], 3'(7 - i)};
      bus(1'b1, OFS_AUDIO_FMT, d);
      rd_exp(OFS_AUDIO_FMT, d & 16'hCF3F);
      check(32'(fmt_cfg), {14'h0, i[1:0], wbits[i[1:0]], f, dac_h[i], adc_h[7 - i]},
        "format outputs");
    end
    bus(1'b1, 4'h5, 16'($random(seed)));
    rd_exp(4'h5, 16'h0000);
    bus(1'b1, OFS_RSVD_FILL, {8'hFF, r[7:0]});
    rd_exp(OFS_RSVD_FILL, 16'hFF00);
    rd_exp(OFS_AUDIO_FMT, d & 16'hCF3F);
    $display("format test done");
    bus(1'b1, OFS_AUDIO_FMT, 16'h0008);
    repeat (2) @(posedge ref_clk);
    n = 0;
    m = 0;
    for (int k = 0; k < 48; k++)
    begin
      @(posedge ref_clk);
      fsref_tick <= (k % 4 == 0);
      n += int'(playback_fs_tick);
      m += int'(record_fs_tick);
    end
    check(n, 8, "playback ticks");
    check(m, 12, "record ticks");
    $display("rate test done");
    d = {1'b0, 7'h12, 3'h5, 4'h9, 1'b0};
    bus(1'b1, OFS_INPUT_GAIN, d);
    rd_exp(OFS_INPUT_GAIN, d);
    check(32'({applied_gain, auto_gain_target_level, auto_gain_time_constants}),
      {16'h0, 9'h024, 3'h5, 4'h9}, "manual gain");
    headset_selected <= 1'b1;
    level_half_db <= 8'h00;
    bus(1'b1, OFS_INPUT_GAIN, 16'h8200);
    bus(1'b1, OFS_INPUT_GAIN, 16'h8201);
    repeat (3) @(posedge ref_clk);
    check(32'(applied_gain), 32'h005, "gain loop load");
    wait_gain(7'h00, 400);
    rd_exp(OFS_INPUT_GAIN, 16'h0001);
    headset_selected <= 1'b0;
    rd_exp(OFS_INPUT_GAIN, 16'h8201);
    level_half_db <= 8'hFF;
    bus(1'b1, OFS_INPUT_GAIN, 16'h7C00);
    bus(1'b1, OFS_INPUT_GAIN, 16'h7DE1);
    wait_gain(7'h7F, 3000);
    repeat (1100) @(posedge ref_clk);
    check(32'(applied_gain), 32'h0FF, "gain cap");
    bus(1'b1, OFS_INPUT_GAIN, 16'h8500);
    repeat (2) @(posedge ref_clk);
    check(32'(applied_gain), 32'h10A, "gain loop off");
    $display("gain test done");
    repeat (3) @(posedge ref_clk);
    print_verdict();
  end
endmodule

bind afr_regs afr_regs_properties afr_regs_properties_inst (
  .ref_clk(ref_clk),
  .rst(rst),
  .bus_req(bus_req),
  .rdata(rdata),
  .fsref_tick(fsref_tick),
  .fmt_cfg(fmt_cfg),
  .applied_gain(applied_gain),
  .auto_gain_target_level(auto_gain_target_level),
  .auto_gain_time_constants(auto_gain_time_constants),
  .playback_fs_tick(playback_fs_tick),
  .record_fs_tick(record_fs_tick)
);
